// ---- core/sector_guard.sv ----
// per-sector guard bits, guard lock, password unlock and mode register
// Contract
// - volatile guard matters only where persistent guard is 1
// - volatile write stores 0 protect, 1 unprotect, unlimited times
// - lock bit 0 of lock register; 0 freezes persistent guards
// - lock-clear command clears lock in either mode
// - persistent mode: lock set at reset, no command sets it
// - software reset leaves the lock bit unchanged
// - password mode: lock cleared at reset, only unlock sets it
// - unprotected only when both guards 1; persistent changeable under lock
// - volatile guards reset; persistent guards survive reset
// - unlock needs all 64 bits equal to stored password
// - mismatch sets program error, keeps pending, lock stays 0
// - unlock accepted at most once per 100 us, pending meanwhile
// - matching password clears pending without the throttle delay; the code ignores any frame during the throttle
// - password programming only turns ones into zeros, no error
// - password reads all ones unprogrammed; reachable by four commands
// - in password mode password program ignored, read undefined
// - mode bits have no erase; once programmed stay programmed
// - ecc status only for readable sectors; boot sector under read protect
// - lock 0 refuses persistent program and erase with failure
// - mode bits 2:1: 11 unselected, 10 persistent, 01 password, 00 illegal
// - sector protected if block-protect or guard scheme protects it
`timescale 1ns/1ps
`default_nettype none
module sector_guard #(
    parameter int THROTTLE_CYCLES = sector_guard_pkg::THROTTLE_CYCLES
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic factory_init,
    // protection command port
    input wire logic cmd_valid,
    input wire sector_guard_pkg::cmd_t cmd,
    output sector_guard_pkg::rsp_t rsp,
    input wire logic clear_error,
    // password unlock link
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic link_din,
    // sector query
    input wire logic [sector_guard_pkg::SECTOR_W-1:0] query_sector,
    input wire logic block_protect,
    output logic sector_protected,
    // ecc status routing
    input wire logic read_protect,
    input wire logic [sector_guard_pkg::SECTOR_W-1:0] ecc_sector,
    output logic [sector_guard_pkg::SECTOR_W-1:0] ecc_report_sector,
    output logic ecc_report_valid,
    // status
    output logic op_pending_flag,
    output logic prog_error,
    output logic [sector_guard_pkg::LOCK_W-1:0] guard_lock_register,
    output logic [sector_guard_pkg::MODE_W-1:0] protection_mode_register
);
    localparam logic [sector_guard_pkg::THR_W-1:0] THR_LOAD =
        sector_guard_pkg::THR_W'(THROTTLE_CYCLES - 1);

    logic [sector_guard_pkg::NUM_SECTORS-1:0] sector_volatile_guard;
    logic [sector_guard_pkg::NUM_SECTORS-1:0] sector_persistent_guard;
    logic [sector_guard_pkg::PASS_W-1:0] password;
    logic [1:0] mode_bits;
    logic lock;
    sector_guard_pkg::unlock_state_t state;
    logic [sector_guard_pkg::THR_W-1:0] thr_count;
    sector_guard_pkg::pass_frame_t frame;
    logic password_mode;
    logic accept;
    logic unlock_ok;
    logic unlock_bad;
    logic cmd_err;
    logic [1:0] mode_wr;

    // a sector is open only when both guards are open
    function automatic logic guard_open(input logic nv, input logic vol);
        guard_open = nv && vol;
    endfunction

    // password programming can only pull cells to zero
    function automatic logic [sector_guard_pkg::PASS_W-1:0] pass_after(
        input logic [sector_guard_pkg::PASS_W-1:0] old,
        input logic [sector_guard_pkg::PASS_W-1:0] wr);
        pass_after = old & wr;
    endfunction

    // mode programming is legal only while unselected and not to the illegal 00
    function automatic logic mode_prog_ok(input logic [1:0] cur, input logic [1:0] wr);
        mode_prog_ok = (cur == sector_guard_pkg::MODE_UNSEL)
            && ((cur & wr) != sector_guard_pkg::MODE_ILLEGAL);
    endfunction

    password_shift_in u_shift (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .link_clk(link_clk),
        .link_sel_n(link_sel_n),
        .link_din(link_din),
        .frame(frame)
    );

    // 01 selects password mode; 11, 10 and the illegal 00 act persistent
    assign password_mode = (mode_bits == sector_guard_pkg::MODE_PASSWORD);

    // mode field carried by a mode-register write
    assign mode_wr = cmd.data[sector_guard_pkg::MODE_HI:sector_guard_pkg::MODE_LO];

    // commands wait out the unlock throttle and the post-reset lock load
    assign accept = cmd_valid && (state == sector_guard_pkg::ST_IDLE);

    // unlock decision outside the throttle; success only in password mode
    assign unlock_ok = frame.valid && (state == sector_guard_pkg::ST_IDLE)
        && password_mode && frame.full && (frame.word == password);
    assign unlock_bad = frame.valid && (state == sector_guard_pkg::ST_IDLE)
        && !unlock_ok;

    // failures that count as program errors
    always_comb begin
        cmd_err = 1'b0;
        if (accept) begin
            case (cmd.op)
                sector_guard_pkg::OP_PG_PROG,
                sector_guard_pkg::OP_PG_ERASE: begin
                    cmd_err = !lock;
                end
                sector_guard_pkg::OP_MODE_PROG: begin
                    cmd_err = !mode_prog_ok(mode_bits, mode_wr);
                end
                sector_guard_pkg::OP_ANY_WRITE: begin
                    cmd_err = (cmd.sel == sector_guard_pkg::SEL_MODE)
                        && !mode_prog_ok(mode_bits, mode_wr);
                end
                default: begin
                    cmd_err = 1'b0;
                end
            endcase
        end
    end

    // unlock sequencer: reset load, idle, throttle after a failed unlock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= sector_guard_pkg::ST_INIT;
            thr_count <= '0;
        end else begin
            case (state)
                sector_guard_pkg::ST_INIT: begin
                    state <= sector_guard_pkg::ST_IDLE;
                end
                sector_guard_pkg::ST_IDLE: begin
                    if (unlock_bad) begin
                        state <= sector_guard_pkg::ST_THROTTLE;
                        thr_count <= THR_LOAD;
                    end
                end
                sector_guard_pkg::ST_THROTTLE: begin
                    if (thr_count == '0) begin
                        state <= sector_guard_pkg::ST_IDLE;
                    end else begin
                        thr_count <= thr_count - 1'b1;
                    end
                end
                default: begin
                    state <= sector_guard_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // pending stays up for the whole throttle; a match never raises it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_pending_flag <= 1'b0;
        end else if (unlock_bad) begin
            op_pending_flag <= 1'b1;
        end else if (state == sector_guard_pkg::ST_THROTTLE && thr_count == '0) begin
            op_pending_flag <= 1'b0;
        end else if (unlock_ok) begin
            op_pending_flag <= 1'b0;
        end
    end

    // sticky program error; a new error wins over the clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_error <= 1'b0;
        end else if (unlock_bad || cmd_err) begin
            prog_error <= 1'b1;
        end else if (clear_error) begin
            prog_error <= 1'b0;
        end
    end

    // reset can only load a constant, so the mode-dependent value lands
    // one cycle after release; soft reset does not touch the lock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock <= 1'b0;
        end else if (state == sector_guard_pkg::ST_INIT) begin
            lock <= !password_mode;
        end else if (accept && cmd.op == sector_guard_pkg::OP_LOCK_CLR) begin
            lock <= 1'b0;
        end else if (unlock_ok) begin
            lock <= 1'b1;
        end
    end

    // volatile guards: free to write, back to open on any reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sector_volatile_guard <= '1;
        end else if (soft_rst) begin
            sector_volatile_guard <= '1;
        end else if (accept && cmd.op == sector_guard_pkg::OP_VG_WRITE) begin
            sector_volatile_guard[cmd.sel] <= cmd.data[0];
        end
    end

    // persistent guards have no reset, they model non-volatile cells
    always_ff @(posedge sys_clk) begin
        if (factory_init) begin
            sector_persistent_guard <= '1;
        end else if (accept && lock) begin
            if (cmd.op == sector_guard_pkg::OP_PG_PROG) begin
                sector_persistent_guard[cmd.sel] <= sector_guard_pkg::GUARD_SHUT;
            end else if (cmd.op == sector_guard_pkg::OP_PG_ERASE) begin
                sector_persistent_guard <= '1;
            end
        end
    end

    // password cells, frozen once password mode is chosen
    always_ff @(posedge sys_clk) begin
        if (factory_init) begin
            password <= sector_guard_pkg::PASS_FACTORY;
        end else if (accept && !password_mode) begin
            if (cmd.op == sector_guard_pkg::OP_PASS_PROG
                || (cmd.op == sector_guard_pkg::OP_ANY_WRITE
                && cmd.sel == sector_guard_pkg::SEL_PASS)) begin
                password <= pass_after(password, cmd.data);
            end
        end
    end

    // mode bits: program only, no erase path exists
    always_ff @(posedge sys_clk) begin
        if (factory_init) begin
            mode_bits <= sector_guard_pkg::MODE_FACTORY[sector_guard_pkg::MODE_HI:
                sector_guard_pkg::MODE_LO];
        end else if (accept && !cmd_err
            && (cmd.op == sector_guard_pkg::OP_MODE_PROG
            || (cmd.op == sector_guard_pkg::OP_ANY_WRITE
            && cmd.sel == sector_guard_pkg::SEL_MODE))) begin
            mode_bits <= mode_bits & mode_wr;
        end
    end

    // command answers, one cycle after acceptance
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp <= '0;
        end else begin
            rsp.done <= accept && cmd.op != sector_guard_pkg::OP_NONE;
            rsp.fail <= cmd_err;
            rsp.data <= '0;
            if (accept) begin
                case (cmd.op)
                    sector_guard_pkg::OP_VG_READ: begin
                        rsp.data[0] <= sector_volatile_guard[cmd.sel];
                    end
                    sector_guard_pkg::OP_PG_READ: begin
                        rsp.data[0] <= sector_persistent_guard[cmd.sel];
                    end
                    sector_guard_pkg::OP_LOCK_READ: begin
                        rsp.data[sector_guard_pkg::LOCK_BIT] <= lock;
                    end
                    sector_guard_pkg::OP_PASS_READ: begin
                        rsp.data <= password_mode ? sector_guard_pkg::PASS_HIDDEN_READ
                            : password;
                    end
                    sector_guard_pkg::OP_ANY_READ: begin
                        if (cmd.sel == sector_guard_pkg::SEL_LOCK) begin
                            rsp.data[sector_guard_pkg::LOCK_BIT] <= lock;
                        end else if (cmd.sel == sector_guard_pkg::SEL_MODE) begin
                            rsp.data[sector_guard_pkg::MODE_W-1:0] <= protection_mode_word();
                        end else if (cmd.sel == sector_guard_pkg::SEL_PASS) begin
                            rsp.data <= password_mode ? sector_guard_pkg::PASS_HIDDEN_READ
                                : password;
                        end
                    end
                    default: begin
                        rsp.data <= '0;
                    end
                endcase
            end
        end
    end

    // mode register image: unused bits read as ones like erased cells
    function automatic logic [sector_guard_pkg::MODE_W-1:0] protection_mode_word();
        logic [sector_guard_pkg::MODE_W-1:0] w;
        w = sector_guard_pkg::MODE_FACTORY;
        w[sector_guard_pkg::MODE_HI:sector_guard_pkg::MODE_LO] = mode_bits;
        protection_mode_word = w;
    endfunction

    // registered status views
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            guard_lock_register <= '0;
            protection_mode_register <= sector_guard_pkg::MODE_FACTORY;
        end else begin
            guard_lock_register <= '0;
            guard_lock_register[sector_guard_pkg::LOCK_BIT] <= lock;
            protection_mode_register <= protection_mode_word();
        end
    end

    // block-protect and guard scheme combine by or
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sector_protected <= 1'b1;
        end else begin
            sector_protected <= block_protect
                || !guard_open(sector_persistent_guard[query_sector],
                sector_volatile_guard[query_sector]);
        end
    end

    // ecc status: under read protection only the boot sector is readable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ecc_report_sector <= sector_guard_pkg::BOOT_SECTOR;
            ecc_report_valid <= 1'b0;
        end else if (read_protect) begin
            ecc_report_sector <= sector_guard_pkg::BOOT_SECTOR;
            ecc_report_valid <= 1'b1;
        end else begin
            ecc_report_sector <= ecc_sector;
            ecc_report_valid <= 1'b1;
        end
    end
endmodule // sector_guard
`default_nettype wire

// ---- core/sector_guard_pkg.sv ----
// shared constants, types and timing for the sector guard logic
package sector_guard_pkg;

    // geometry
    localparam int NUM_SECTORS = 256;
    localparam int SECTOR_W = 8;
    localparam int PASS_W = 64;
    localparam int PASS_CNT_W = 7;
    localparam logic [PASS_CNT_W-1:0] PASS_BITS = 7'h40;
    localparam logic [SECTOR_W-1:0] BOOT_SECTOR = 8'h00;

    // guard-lock register layout
    localparam int LOCK_W = 8;
    localparam int LOCK_BIT = 0;

    // protection-mode register layout
    localparam int MODE_W = 8;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 1;
    localparam logic [1:0] MODE_UNSEL = 2'h3;
    localparam logic [1:0] MODE_PERSIST = 2'h2;
    localparam logic [1:0] MODE_PASSWORD = 2'h1;
    localparam logic [1:0] MODE_ILLEGAL = 2'h0;
    localparam logic [MODE_W-1:0] MODE_FACTORY = 8'hFF;

    // factory and reset values
    localparam logic [PASS_W-1:0] PASS_FACTORY = 64'hFFFFFFFFFFFFFFFF;
    localparam logic [PASS_W-1:0] PASS_HIDDEN_READ = 64'h0000000000000000;
    localparam logic GUARD_OPEN = 1'b1;
    localparam logic GUARD_SHUT = 1'b0;

    // register selects for the generic register commands
    localparam logic [SECTOR_W-1:0] SEL_LOCK = 8'h00;
    localparam logic [SECTOR_W-1:0] SEL_MODE = 8'h01;
    localparam logic [SECTOR_W-1:0] SEL_PASS = 8'h02;

    // unlock throttle
    localparam int CLK_PERIOD_PS = 5000;
    localparam int THROTTLE_NS = 100000;
    localparam int THROTTLE_CYCLES =
        (THROTTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int THR_W = 16;

    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_VG_WRITE  = 4'h1,
        OP_VG_READ   = 4'h2,
        OP_PG_PROG   = 4'h3,
        OP_PG_ERASE  = 4'h4,
        OP_PG_READ   = 4'h5,
        OP_LOCK_CLR  = 4'h6,
        OP_LOCK_READ = 4'h7,
        OP_PASS_PROG = 4'h8,
        OP_PASS_READ = 4'h9,
        OP_MODE_PROG = 4'hA,
        OP_ANY_READ  = 4'hB,
        OP_ANY_WRITE = 4'hC
    } op_t;

    typedef struct packed {
        op_t op;
        logic [SECTOR_W-1:0] sel;
        logic [PASS_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic done;
        logic fail;
        logic [PASS_W-1:0] data;
    } rsp_t;

    typedef struct packed {
        logic valid;
        logic full;
        logic [PASS_W-1:0] word;
    } pass_frame_t;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_INIT     = 2'b01,
        ST_THROTTLE = 2'b10
    } unlock_state_t;

endpackage

// ---- core/password_shift_in.sv ----
// serial capture of a password unlock frame sampled from the link pins
`timescale 1ns/1ps
`default_nettype none
module password_shift_in (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // link pins, foreign domain
    input wire logic link_clk,
    input wire logic link_sel_n,
    input wire logic link_din,
    // captured frame
    output sector_guard_pkg::pass_frame_t frame
);
    logic [2:0] meta;
    logic [2:0] sync;
    logic clk_prev;
    logic sel_prev;
    logic [sector_guard_pkg::PASS_W-1:0] shift;
    logic [sector_guard_pkg::PASS_CNT_W-1:0] count;
    logic over;

    // two-stage synchronisers, first stage read only by the second
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 3'h4;
            sync <= 3'h4;
        end else begin
            meta <= {link_sel_n, link_clk, link_din};
            sync <= meta;
        end
    end

    // edge history on the synchronised levels
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_prev <= 1'b0;
            sel_prev <= 1'b1;
        end else begin
            clk_prev <= sync[1];
            sel_prev <= sync[2];
        end
    end

    // msb first shifting; a bit past the 64th marks the frame as bad
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift <= '0;
            count <= '0;
            over <= 1'b0;
        end else if (sync[2]) begin
            count <= '0;
            over <= 1'b0;
        end else if (sync[1] && !clk_prev) begin
            shift <= {shift[sector_guard_pkg::PASS_W-2:0], sync[0]};
            if (count == sector_guard_pkg::PASS_BITS) begin
                over <= 1'b1;
            end else begin
                count <= count + 1'b1;
            end
        end
    end

    // frame reported on the rising edge of the select
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame <= '0;
        end else begin
            frame.valid <= sync[2] && !sel_prev;
            frame.full <= (count == sector_guard_pkg::PASS_BITS) && !over;
            frame.word <= shift;
        end
    end
endmodule // password_shift_in
`default_nettype wire

// ---- bench/sector_guard_checker.sv ----
// port-level assertions for the sector guard
`timescale 1ns/1ps
`default_nettype none
module sector_guard_checker #(
    parameter int THROTTLE_CYCLES = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_valid,
    input wire sector_guard_pkg::cmd_t cmd,
    input wire sector_guard_pkg::rsp_t rsp,
    // protection and ecc
    input wire logic block_protect,
    input wire logic sector_protected,
    input wire logic read_protect,
    input wire logic [7:0] ecc_report_sector,
    // status
    input wire logic op_pending_flag,
    input wire logic prog_error,
    input wire logic [7:0] guard_lock_register,
    input wire logic [7:0] protection_mode_register
);
    logic [1:0] up_cnt;
    logic [15:0] pend_cnt;
    wire logic lock = guard_lock_register[0];
    wire logic [1:0] mode = protection_mode_register[2:1];
    // edges since reset release; the first edge refuses commands
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    // length of the running pending stretch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) pend_cnt <= 16'h0;
        else pend_cnt <= op_pending_flag ? pend_cnt + 16'h1 : 16'h0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // a command the unit is free to take
    sequence s_taken;
        cmd_valid && !op_pending_flag && up_cnt != 2'h0;
    endsequence
    a_cmd_answered: assert property (s_taken |=> rsp.done)
        else $error("taken command not answered");
    a_pending_refuses: assert property (cmd_valid && op_pending_flag |=> !rsp.done)
        else $error("command answered while pending");
    a_pending_errors: assert property ($rose(op_pending_flag) |-> prog_error)
        else $error("throttle without error flag");
    a_throttle_span: assert property ($fell(op_pending_flag) |-> pend_cnt == THROTTLE_CYCLES)
        else $error("throttle length wrong");
    a_clear_drops_lock: assert property (s_taken ##0 cmd.op == sector_guard_pkg::OP_LOCK_CLR
        |-> ##[1:2] !lock)
        else $error("lock not cleared");
    a_locked_refuses: assert property (s_taken ##0 (cmd.op == sector_guard_pkg::OP_PG_PROG
        || cmd.op == sector_guard_pkg::OP_PG_ERASE) ##0 (!lock && !$past(lock)) |=> rsp.fail)
        else $error("persistent change not refused");
    a_reset_lock_set: assert property (up_cnt == 2'h2 && mode != 2'h1 |-> lock)
        else $error("lock not set after reset");
    a_lock_rise_legal: assert property ($rose(lock) |-> up_cnt == 2'h2 || mode == 2'h1)
        else $error("lock set by command in persistent mode");
    a_block_forces: assert property (block_protect |=> sector_protected)
        else $error("block protect ignored");
    a_ecc_boot: assert property (read_protect |=> ecc_report_sector == 8'h00)
        else $error("ecc sector not forced to boot");
endmodule // sector_guard_checker
bind sector_guard sector_guard_checker #(.THROTTLE_CYCLES(THROTTLE_CYCLES)) chk (.*);
`default_nettype wire

// ---- bench/unlock_host.sv ----
// host model sending password unlock frames on the link pins
`timescale 1ns/1ps
`default_nettype none
module unlock_host (
    // link pins
    output var logic link_clk,
    output var logic link_sel_n,
    output var logic link_din
);
    // clock idles low outside frames; data inverts after a frame
    task automatic send(input logic [63:0] word);
        link_sel_n = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            link_din = word[i];
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        #80 link_sel_n = 1'b1;
        link_din = ~link_din;
    endtask
    // idle pins at time zero
    initial begin
        {link_clk, link_sel_n, link_din} = 3'h2;
    end
endmodule // unlock_host
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the sector guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {
        logic [3:0] op;
        logic [7:0] sel;
        logic d, fail;
        logic [7:0] q;
        logic prot, lock;
    } row_t;
    logic sys_clk, sys_rst, soft_rst, factory_init, cmd_valid, clear_error;
    logic block_protect, read_protect, sector_protected, ecc_report_valid;
    logic op_pending_flag, prog_error, link_clk, link_sel_n, link_din;
    logic [7:0] query_sector, ecc_sector, ecc_report_sector;
    logic [7:0] guard_lock_register, protection_mode_register;
    sector_guard_pkg::cmd_t cmd;
    sector_guard_pkg::rsp_t rsp;
    int mismatches, check_count;
    localparam logic [63:0] KEY = 64'h5A5AC3C30F0F1234;
    // op, sector, data bit, fail, query, protected, lock
    row_t rows [9] = '{
        '{4'h1, 8'h05, 1'b0, 1'b0, 8'h05, 1'b1, 1'b1},
        '{4'h1, 8'h05, 1'b1, 1'b0, 8'h05, 1'b0, 1'b1},
        '{4'h3, 8'h07, 1'b0, 1'b0, 8'h07, 1'b1, 1'b1},
        '{4'h1, 8'h07, 1'b1, 1'b0, 8'h07, 1'b1, 1'b1},
        '{4'h4, 8'h00, 1'b1, 1'b0, 8'h07, 1'b0, 1'b1},
        '{4'h3, 8'h09, 1'b0, 1'b0, 8'h09, 1'b1, 1'b1},
        '{4'h6, 8'h00, 1'b0, 1'b0, 8'h09, 1'b1, 1'b0}, // guards set first
        '{4'h4, 8'h00, 1'b1, 1'b1, 8'h09, 1'b1, 1'b0},
        '{4'h6, 8'h00, 1'b0, 1'b0, 8'h09, 1'b1, 1'b0}};
    sector_guard #(.THROTTLE_CYCLES(20)) uut (.*);
    unlock_host host (.*);
    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held over one rising edge; answer read on return
    task automatic issue(input logic [3:0] op, input logic [7:0] sel, input logic [63:0] data);
        @(negedge sys_clk);
        cmd = '{sector_guard_pkg::op_t'(op), sel, data};
        cmd_valid = 1'b1;
        @(negedge sys_clk) cmd_valid = 1'b0;
    endtask
    task automatic hw_reset;
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    // bounded poll of the pending flag
    task automatic wait_idle;
        for (int n = 0; n < 200 && op_pending_flag !== 1'b0; n++) @(negedge sys_clk);
        check("idle", 0, op_pending_flag);
        clear_error = 1'b1;
        @(negedge sys_clk) clear_error = 1'b0;
    endtask
    task automatic unlock(input logic [63:0] word);
        host.send(word);
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic conclude;
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // the whole run takes well under 100 us
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    initial begin
        {sys_rst, soft_rst, factory_init, cmd_valid, clear_error} = 5'h14;
        {block_protect, read_protect} = 2'h0;
        {query_sector, ecc_sector} = 16'h0033;
        cmd = '0;
        mismatches = 0;
        check_count = 0;
        hw_reset();
        factory_init = 1'b0;
        check("mode", 8'hFF, protection_mode_register);
        foreach (rows[i]) begin
            query_sector = rows[i].q;
            issue(rows[i].op, rows[i].sel, {63'h0, rows[i].d});
            check("done", 1, rsp.done);
            check("fail", rows[i].fail, rsp.fail);
            @(negedge sys_clk);
            check("protected", rows[i].prot, sector_protected);
            check("lock", rows[i].lock, guard_lock_register);
        end
        // soft reset: volatile guards reopen, lock kept
        issue(4'h1, 8'h05, 64'h0);
        query_sector = 8'h05;
        soft_rst = 1'b1;
        @(negedge sys_clk) soft_rst = 1'b0;
        @(negedge sys_clk);
        check("soft lock", 0, guard_lock_register);
        check("soft vol", 0, sector_protected);
        {block_protect, read_protect} = 2'h3;
        repeat (2) @(negedge sys_clk);
        check("block", 1, sector_protected);
        check("ecc", 8'h00, ecc_report_sector);
        {block_protect, read_protect} = 2'h0;
        query_sector = 8'h09;
        hw_reset();
        check("ecc free", 8'h33, ecc_report_sector);
        check("ecc valid", 1, ecc_report_valid);
        check("hw lock", 1, guard_lock_register);
        check("kept", 1, sector_protected);
        unlock(KEY);
        check("pers pend", 1, op_pending_flag);
        check("pers err", 1, prog_error);
        issue(4'h7, 8'h00, 64'h0);
        check("refused", 0, rsp.done);
        wait_idle();
        // password setup, then select password mode
        issue(4'h9, 8'h00, 64'h0);
        check("blank", 64'hFFFFFFFFFFFFFFFF, rsp.data);
        issue(4'h8, 8'h00, KEY);
        issue(4'h8, 8'h00, 64'hFFFFFFFFFFFFFFFF);
        check("one over zero", 0, rsp.fail);
        issue(4'h9, 8'h00, 64'h0);
        check("pass", KEY, rsp.data);
        issue(4'hA, 8'h01, 64'hFFFFFFFFFFFFFFFB);
        issue(4'hA, 8'h01, 64'hFFFFFFFFFFFFFFFD);
        check("mode fail", 1, rsp.fail);
        check("mode", 8'hFB, protection_mode_register);
        issue(4'h9, 8'h00, 64'h0);
        check("hidden", sector_guard_pkg::PASS_HIDDEN_READ, rsp.data);
        wait_idle();
        hw_reset();
        check("pw lock", 0, guard_lock_register);
        unlock(~KEY);
        check("bad lock", 0, guard_lock_register);
        check("bad err", 1, prog_error);
        wait_idle();
        unlock(KEY);
        check("good lock", 1, guard_lock_register);
        check("good pend", 0, op_pending_flag);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
